// ===== rtl/dac_array_ctrl.sv
// DIMM DRAM array controller: sizing, bank decode, strobes and burst timing.
`timescale 1ns/1ps
`include "dac_defs.svh"
// Functional notes
// - DIMMs of 8, 16, 32, 64 or 128 MB are sized and addressed.
// - Eight non-interleaved banks, one per DIMM, each 64 data plus ECC bits.
// - One active-low row strobe per bank; column strobes shared by all banks.
// - Type and size detected; banks allocated without outside help.
// - Four or fewer DIMMs: EDO x-2-2-2, FPM x-3-3-3.
// - Five to eight DIMMs: EDO x-3-3-3, FPM x-4-4-4.
// - Total memory 8 MB to 1 GB of FPM or EDO DRAM.
// - ECC corrects single-bit errors, detects double and some wider errors.
// - ECC is off after reset until software enables it.
module dac_array_ctrl
  import dac_pkg::*;
#(
  parameter int NUM_BANKS = `DAC_NUM_BANKS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // DIMM presence detect pins
  input wire logic [NUM_BANKS-1:0] dimm_present,
  input wire logic [3*NUM_BANKS-1:0] dimm_size_code,
  input wire logic [NUM_BANKS-1:0] dimm_is_edo,
  // Requests and responses on the host side
  input wire logic ecc_enable,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`DAC_ADDR_W-1:0] req_addr,
  input wire logic [63:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [63:0] rsp_rdata,
  output logic rsp_miss,
  output logic ecc_single_err,
  output logic ecc_multi_err,
  // Status
  output logic init_done,
  output logic [3:0] dimm_count,
  output logic [`DAC_ADDR_W:0] mem_top,
  output logic [2:0] burst_cycles,
  // DRAM array pins
  output logic [NUM_BANKS-1:0] bank_row_strobe_n,
  output logic [7:0] shared_column_strobe_n,
  output logic dram_we_n,
  output logic [`DAC_ROW_W-1:0] dram_addr,
  output logic [63:0] dram_dq_out,
  output logic [7:0] dram_ecc_out,
  output logic dram_dq_oe_n,
  input wire logic [63:0] dram_dq_in,
  input wire logic [7:0] dram_ecc_in
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int PW = 5 * NUM_BANKS;
  logic [PW-1:0] pin_s1, pin_s2, pin_s3, pin_stable;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_stable <= '0;
    end else begin
      pin_s1 <= {dimm_present, dimm_size_code, dimm_is_edo};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_stable <= pin_s3;
      end
    end
  end
  logic [NUM_BANKS-1:0] pres_q, edo_q;
  logic [3*NUM_BANKS-1:0] size_q;
  assign {pres_q, size_q, edo_q} = pin_stable;

  // ************************************************************
  // Sizing and row boundaries
  // ************************************************************
  // Bank capacity in bytes; codes above 128 MB read as empty.
  function automatic logic [`DAC_ADDR_W:0] bank_bytes(input logic p, input logic [2:0] c);
    if (!p || c > `DAC_SIZE_128MB) begin
      return '0;
    end
    return (`DAC_ADDR_W+1)'(1) << (`DAC_UNIT_SHIFT + int'(c));
  endfunction

  dac_state_t state_reg;
  logic [2:0] settle_reg;
  logic [`DAC_ADDR_W:0] row_boundary_value [NUM_BANKS];
  logic [NUM_BANKS-1:0] bank_edo_reg;
  logic [`DAC_ADDR_W:0] bnd_next [NUM_BANKS];
  logic [`DAC_ADDR_W:0] run_sum;
  // Boundaries are cumulative, so any gap still maps the banks linearly.
  always_comb begin
    run_sum = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      run_sum = run_sum + bank_bytes(pres_q[b], size_q[3*b +: 3]);
      bnd_next[b] = run_sum;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_boundary_value[b] <= '0;
      end
      bank_edo_reg <= '0;
      dimm_count <= 4'h0;
      mem_top <= '0;
      settle_reg <= 3'h0;
    end else if (state_reg == DAC_INIT) begin
      settle_reg <= settle_reg + 3'h1;
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_boundary_value[b] <= bnd_next[b];
      end
      bank_edo_reg <= edo_q & pres_q;
      dimm_count <= 4'($countones(pres_q));
      mem_top <= bnd_next[NUM_BANKS-1];
    end
  end

  // Mixed types fall back to FPM timing, the safer of the two.
  logic all_edo;
  assign all_edo = (bank_edo_reg == pres_q) && (pres_q != '0);
  always_ff @(posedge clk) begin
    if (srst) begin
      burst_cycles <= `DAC_FPM_SLOW;
    end else if (dimm_count <= `DAC_FAST_MAX_DIMMS) begin
      burst_cycles <= all_edo ? `DAC_EDO_FAST : `DAC_FPM_FAST;
    end else begin
      burst_cycles <= all_edo ? `DAC_EDO_SLOW : `DAC_FPM_SLOW;
    end
  end

  // ************************************************************
  // Bank decode
  // ************************************************************
  logic [NUM_BANKS-1:0] hit;
  logic [NUM_BANKS-1:0] sel;
  always_comb begin
    hit = '0;
    sel = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      hit[b] = {1'b0, req_addr} < row_boundary_value[b];
    end
    sel = hit & ~{hit[NUM_BANKS-2:0], 1'b0};
  end

  // ************************************************************
  // Access sequencer
  // ************************************************************
  logic [2:0] cnt_reg;
  logic [1:0] beat_reg;
  logic [NUM_BANKS-1:0] sel_reg;
  logic write_reg;
  logic [`DAC_ADDR_W-1:0] addr_reg;
  logic [63:0] wdata_reg;
  assign req_ready = (state_reg == DAC_IDLE);
  assign init_done = (state_reg != DAC_INIT);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= DAC_INIT;
      cnt_reg <= 3'h0;
      beat_reg <= 2'h0;
      sel_reg <= '0;
      write_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      rsp_miss <= 1'b0;
    end else begin
      case (state_reg)
        DAC_INIT: begin
          if (settle_reg == 3'h7) begin
            state_reg <= DAC_IDLE;
          end
        end
        DAC_IDLE: begin
          rsp_miss <= 1'b0;
          if (req_valid) begin
            sel_reg <= sel;
            write_reg <= req_write;
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
            cnt_reg <= `DAC_LEAD_CYCLES;
            beat_reg <= 2'h0;
            if (sel == '0) begin
              rsp_miss <= 1'b1;
              state_reg <= DAC_DONE;
            end else begin
              state_reg <= DAC_ROW;
            end
          end
        end
        DAC_ROW: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            cnt_reg <= burst_cycles;
            state_reg <= DAC_COL;
          end
        end
        DAC_COL: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            cnt_reg <= burst_cycles;
            beat_reg <= beat_reg + 2'h1;
            if (beat_reg == `DAC_BURST_BEATS) begin
              state_reg <= DAC_PRE;
            end
          end
        end
        DAC_PRE: begin
          state_reg <= DAC_DONE;
        end
        DAC_DONE: begin
          state_reg <= DAC_IDLE;
        end
        default: begin
          state_reg <= DAC_INIT;
        end
      endcase
    end
  end

  // Column strobe is low for the last burst_cycles>>1 cycles of each beat period.
  logic col_low;
  assign col_low = (state_reg == DAC_COL) && (cnt_reg <= (burst_cycles >> 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      bank_row_strobe_n <= '1;
      shared_column_strobe_n <= 8'hff;
      dram_addr <= '0;
      dram_we_n <= 1'b1;
      dram_dq_oe_n <= 1'b1;
    end else begin
      bank_row_strobe_n <= (state_reg == DAC_ROW || state_reg == DAC_COL) ? ~sel_reg : '1;
      shared_column_strobe_n <= {8{~col_low}};
      dram_addr <= (state_reg == DAC_ROW) ? addr_reg[`DAC_ADDR_W-1 -: `DAC_ROW_W]
        : {{(`DAC_ROW_W-`DAC_COL_W){1'b0}}, addr_reg[`DAC_COL_W+2:5], beat_reg};
      dram_we_n <= !(write_reg && state_reg == DAC_COL);
      dram_dq_oe_n <= !(write_reg && state_reg == DAC_COL);
    end
  end

  // ************************************************************
  // Data path and ECC
  // ************************************************************
  logic [63:0] corr_data;
  logic [7:0] wr_check;
  logic ecc_single_now, ecc_multi_now;
  dac_ecc u_ecc (
    .clk(clk),
    .srst(srst),
    .wr_data(wdata_reg),
    .rd_data(dram_dq_in),
    .rd_check(dram_ecc_in),
    .ecc_enable(ecc_enable),
    .wr_check(wr_check),
    .corr_data(corr_data),
    .single_err(ecc_single_now),
    .multi_err(ecc_multi_now)
  );
  assign dram_ecc_out = wr_check;

  // The last beat reaches corr_data only in the done cycle; flags ride with it, not the idle bus.
  logic rd_capture;
  assign rd_capture = (state_reg == DAC_DONE) && !write_reg && !rsp_miss;
  always_ff @(posedge clk) begin
    if (srst) begin
      dram_dq_out <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      ecc_single_err <= 1'b0;
      ecc_multi_err <= 1'b0;
    end else begin
      dram_dq_out <= wdata_reg;
      rsp_valid <= (state_reg == DAC_DONE);
      if (rd_capture) begin
        rsp_rdata <= corr_data;
      end
      if (!ecc_enable) begin
        ecc_single_err <= 1'b0;
        ecc_multi_err <= 1'b0;
      end else if (rd_capture) begin
        ecc_single_err <= ecc_single_now;
        ecc_multi_err <= ecc_multi_now;
      end
    end
  end
endmodule

// ===== rtl/dac_defs.svh
// Constants for the DIMM DRAM array controller.
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH
`define DAC_NUM_BANKS 8
`define DAC_DATA_W 64
`define DAC_ECC_W 8
`define DAC_ROW_W 12
`define DAC_COL_W 10
`define DAC_ADDR_W 30
`define DAC_FAST_MAX_DIMMS 4
`define DAC_EDO_FAST 3'h2
`define DAC_EDO_SLOW 3'h3
`define DAC_FPM_FAST 3'h3
`define DAC_FPM_SLOW 3'h4
`define DAC_LEAD_CYCLES 3'h3
`define DAC_SIZE_8MB 3'h0
`define DAC_SIZE_128MB 3'h4
`define DAC_UNIT_SHIFT 23
`define DAC_BURST_BEATS 2'h3
`endif

// ===== rtl/dac_ecc.sv
// SEC-DED check bit generation and syndrome decode for one 64-bit word.
`timescale 1ns/1ps
`include "dac_defs.svh"
module dac_ecc
  import dac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Data in
  input wire logic [63:0] wr_data,
  input wire logic [63:0] rd_data,
  input wire logic [7:0] rd_check,
  input wire logic ecc_enable,
  // Results
  output logic [7:0] wr_check,
  output logic [63:0] corr_data,
  output logic single_err,
  output logic multi_err
);
  // Each data bit gets a unique odd-weight column of weight three or more. A single flip
  // is then locatable, and a double flip gives an even syndrome that matches no column.
  function automatic logic [7:0] col_code(input int i);
    logic [6:0] v;
    v = (i == 0) ? 7'h03 : {1'b1, 6'(i)};
    return {~^v, v};
  endfunction

  function automatic logic [7:0] gen_check(input logic [63:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 64; i++) begin
      if (d[i]) begin
        s = s ^ col_code(i);
      end
    end
    return s;
  endfunction

  logic [7:0] syn;
  logic [63:0] flip;
  always_comb begin
    syn = gen_check(rd_data) ^ rd_check;
    flip = '0;
    for (int i = 0; i < 64; i++) begin
      flip[i] = (syn == col_code(i));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_check <= 8'h00;
      corr_data <= '0;
      single_err <= 1'b0;
      multi_err <= 1'b0;
    end else begin
      wr_check <= gen_check(wr_data);
      // Disabled ECC passes data through and flags nothing.
      if (ecc_enable) begin
        corr_data <= rd_data ^ flip;
        single_err <= (syn != 8'h00) && (^syn);
        multi_err <= (syn != 8'h00) && !(^syn);
      end else begin
        corr_data <= rd_data;
        single_err <= 1'b0;
        multi_err <= 1'b0;
      end
    end
  end
endmodule

// ===== rtl/dac_pkg.sv
// Types for the DIMM DRAM array controller.
package dac_pkg;
  typedef enum logic [5:0] {
    DAC_INIT = 6'h01,
    DAC_IDLE = 6'h02,
    DAC_ROW = 6'h04,
    DAC_COL = 6'h08,
    DAC_PRE = 6'h10,
    DAC_DONE = 6'h20
  } dac_state_t;
  typedef enum logic {
    DAC_FPM = 1'b0,
    DAC_EDO = 1'b1
  } dac_dram_t;
endpackage

// ===== testbench/dac_array_ctrl_properties.sv
// Port checker for the DIMM array controller.
`timescale 1ns/1ps
`include "dac_defs.svh"
module dac_chk #(
  parameter int NUM_BANKS = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sizing pins
  input wire logic [NUM_BANKS-1:0] dimm_present,
  input wire logic [3*NUM_BANKS-1:0] dimm_size_code,
  input wire logic [NUM_BANKS-1:0] dimm_is_edo,
  // Requests and status
  input wire logic ecc_enable,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [`DAC_ADDR_W-1:0] req_addr,
  input wire logic rsp_valid,
  input wire logic rsp_miss,
  input wire logic ecc_single_err,
  input wire logic ecc_multi_err,
  input wire logic init_done,
  input wire logic [3:0] dimm_count,
  input wire logic [`DAC_ADDR_W:0] mem_top,
  input wire logic [2:0] burst_cycles,
  // Strobes
  input wire logic [NUM_BANKS-1:0] bank_row_strobe_n,
  input wire logic [7:0] shared_column_strobe_n,
  // Row and column address pins
  input wire logic [`DAC_ROW_W-1:0] dram_addr
);
  logic [`DAC_ADDR_W:0] top;
  logic [`DAC_ADDR_W:0] lo;
  logic [NUM_BANKS-1:0] sel;
  logic [NUM_BANKS-1:0] sel_reg;
  logic edo_all;
  logic take;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Banks stack in socket order, so an empty socket adds nothing below the next one.
  always_comb begin
    top = '0;
    lo = '0;
    sel = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (dimm_present[i]) begin
        lo = top;
        top = top + ((`DAC_ADDR_W+1)'(1) << (`DAC_UNIT_SHIFT + dimm_size_code[3*i +: 3]));
        if ({1'b0, req_addr} >= lo && {1'b0, req_addr} < top) sel[i] = 1'b1;
      end
    end
  end
  assign edo_all = &(dimm_is_edo | ~dimm_present);
  assign take = req_valid && req_ready && init_done;
  always_ff @(posedge clk) begin
    if (take) sel_reg <= sel;
  end
  a_one_row: assert property ($onehot0(~bank_row_strobe_n))
    else $error("more than one row strobe low");
  a_lanes_equal: assert property (&shared_column_strobe_n || ~|shared_column_strobe_n)
    else $error("column strobe lanes differ");
  a_fast_timing: assert property (init_done && $countones(dimm_present) <= 4 |->
    burst_cycles == (edo_all ? 3'h2 : 3'h3)) else $error("fast burst timing wrong");
  a_slow_timing: assert property (init_done && $countones(dimm_present) > 4 |->
    burst_cycles == (edo_all ? 3'h3 : 3'h4)) else $error("slow burst timing wrong");
  a_dimm_count: assert property (init_done |-> dimm_count == $countones(dimm_present))
    else $error("dimm count wrong");
  a_mem_top: assert property (init_done |-> mem_top == top)
    else $error("memory top wrong");
  a_ecc_quiet: assert property (!ecc_enable ##1 !ecc_enable |-> !ecc_single_err && !ecc_multi_err)
    else $error("ecc flag while disabled");
  a_miss_time: assert property (take && sel == '0 |-> ##2 rsp_valid && rsp_miss)
    else $error("miss not answered in two cycles");
  a_row_select: assert property (take && sel != '0 |-> ##[1:4] bank_row_strobe_n == ~sel_reg)
    else $error("wrong bank row strobe");
  a_hit_time: assert property (take && sel != '0 |-> ##[13:23] rsp_valid && !rsp_miss)
    else $error("hit answer late or missing");
  a_row_addr: assert property (take && sel != '0 |->
    ##2 dram_addr == $past(req_addr[`DAC_ADDR_W-1 -: `DAC_ROW_W], 2)) else $error("row address wrong");
endmodule
bind dac_array_ctrl dac_chk #(.NUM_BANKS(NUM_BANKS)) dac_chk_i (.clk, .srst, .dimm_present,
  .dimm_size_code, .dimm_is_edo, .ecc_enable, .req_valid, .req_ready, .req_addr, .rsp_valid,
  .rsp_miss, .ecc_single_err, .ecc_multi_err, .init_done, .dimm_count, .mem_top, .burst_cycles,
  .bank_row_strobe_n, .shared_column_strobe_n, .dram_addr);

// ===== testbench/dac_array_ctrl_test.sv
// Self-checking bench for the DIMM array controller.
`timescale 1ns/1ps
`include "dac_defs.svh"
module dac_array_ctrl_test;
  typedef struct {logic [7:0] p; logic [23:0] s; logic [7:0] e; logic [3:0] n; logic [2:0] b;} dac_row_t;
  // Sockets are filled from zero upward with no gaps.
  dac_row_t rows [6] = '{'{8'h01, 24'h000001, 8'h00, 4'h1, 3'h3}, '{8'h0f, 24'h000924, 8'h0f, 4'h4, 3'h2},
    '{8'h1f, 24'h004688, 8'h1f, 4'h5, 3'h3}, '{8'hff, 24'h924924, 8'h00, 4'h8, 3'h4},
    '{8'h03, 24'h000012, 8'h01, 4'h2, 3'h3}, '{8'hff, 24'h249249, 8'hff, 4'h8, 3'h3}};
  logic clk, srst, ecc_enable, req_valid, req_write, req_ready, rsp_valid, rsp_miss;
  logic ecc_single_err, ecc_multi_err, init_done, dram_we_n, dram_dq_oe_n;
  logic [7:0] dimm_present, dimm_is_edo, bank_row_strobe_n, shared_column_strobe_n, dram_ecc_out;
  logic [7:0] dram_ecc_in;
  logic [23:0] dimm_size_code;
  logic [29:0] req_addr;
  logic [63:0] req_wdata, rsp_rdata, dram_dq_out, dram_dq_in, flip_mask, d;
  logic [3:0] dimm_count;
  logic [30:0] mem_top, top;
  logic [2:0] burst_cycles;
  int fails, samples_checked, cycles;
  dac_array_ctrl dac_array_ctrl_i (.clk, .srst, .dimm_present, .dimm_size_code, .dimm_is_edo,
    .ecc_enable, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid,
    .rsp_rdata, .rsp_miss, .ecc_single_err, .ecc_multi_err, .init_done, .dimm_count, .mem_top,
    .burst_cycles, .bank_row_strobe_n, .shared_column_strobe_n, .dram_we_n, .dram_addr(),
    .dram_dq_out, .dram_ecc_out, .dram_dq_oe_n, .dram_dq_in, .dram_ecc_in);
  dac_dimm_model dac_dimm_model_i (.clk, .bank_row_strobe_n, .shared_column_strobe_n, .dram_we_n,
    .dram_dq_oe_n, .dram_dq_out, .dram_ecc_out, .flip_mask, .dram_dq_in, .dram_ecc_in);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up;
    end
  end
  task wrap_up;
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  function automatic logic [30:0] exp_top(input logic [7:0] p, input logic [23:0] s);
    logic [30:0] t;
    t = '0;
    for (int i = 0; i < 8; i++) begin
      if (p[i]) t = t + (31'h1 << (`DAC_UNIT_SHIFT + s[3*i +: 3]));
    end
    return t;
  endfunction
  task restart(input logic [7:0] p, input logic [23:0] s, input logic [7:0] e);
    int n;
    @(negedge clk);
    srst = 1'b1;
    ecc_enable = 1'b0;
    flip_mask = '0;
    dimm_present = p;
    dimm_size_code = s;
    dimm_is_edo = e;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    n = 0;
    while (init_done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(init_done, 1'b1, "sizing did not finish");
  endtask
  // Entered and left on a falling edge, so calls may follow each other back to back.
  task xfer(input logic wr, input logic [29:0] a, input logic [63:0] wd);
    int n;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(rsp_valid, 1'b1, "no response");
  endtask
  initial begin
    srst = 1'b1;
    {ecc_enable, req_valid, req_write, dimm_present, dimm_is_edo, dimm_size_code} = '0;
    {req_addr, req_wdata, flip_mask} = '0;
    for (int r = 0; r < 6; r++) begin
      restart(rows[r].p, rows[r].s, rows[r].e);
      top = exp_top(rows[r].p, rows[r].s);
      d = 64'h0123456789abcdef + 64'(r);
      check(dimm_count, rows[r].n, "dimm count");
      check(burst_cycles, rows[r].b, "burst timing");
      check(mem_top, top, "memory top");
      xfer(1'b1, top[29:0] - 30'h8, d);
      xfer(1'b0, top[29:0] - 30'h8, '0);
      check(rsp_rdata, d, "read back");
      check(rsp_miss, 1'b0, "false miss");
      if (!top[30]) begin
        xfer(1'b0, top[29:0], '0);
        check(rsp_miss, 1'b1, "miss lost");
      end
    end
    restart(8'h03, 24'h000012, 8'h03);
    d = 64'h5555aaaa3333cccc;
    xfer(1'b1, 30'h10, d);
    flip_mask = 64'h1;
    xfer(1'b0, 30'h10, '0);
    check(ecc_single_err, 1'b0, "ecc active after reset");
    check(rsp_rdata, d ^ 64'h1, "raw data");
    ecc_enable = 1'b1;
    xfer(1'b1, 30'h10, d);
    xfer(1'b0, 30'h10, '0);
    check(rsp_rdata, d, "not corrected");
    check(ecc_single_err, 1'b1, "single flag");
    flip_mask = 64'h3;
    xfer(1'b0, 30'h10, '0);
    check(ecc_multi_err, 1'b1, "double flag");
    wrap_up;
  end
endmodule

// ===== testbench/dac_dimm_model.sv
// Behavioural DIMM set holding one 72-bit word per bank.
`timescale 1ns/1ps
module dac_dimm_model (
  // Clock
  input wire logic clk,
  // Strobes and write path
  input wire logic [7:0] bank_row_strobe_n,
  input wire logic [7:0] shared_column_strobe_n,
  input wire logic dram_we_n,
  input wire logic dram_dq_oe_n,
  input wire logic [63:0] dram_dq_out,
  input wire logic [7:0] dram_ecc_out,
  // Error injection
  input wire logic [63:0] flip_mask,
  // Read path
  output logic [63:0] dram_dq_in,
  output logic [7:0] dram_ecc_in
);
  logic [71:0] word_reg [8];
  logic [71:0] last_reg = '0;
  logic [2:0] bank;
  logic col_on;
  logic rd_on;
  always_comb begin
    bank = '0;
    for (int i = 0; i < 8; i++) begin
      if (!bank_row_strobe_n[i]) bank = 3'(i);
    end
  end
  assign col_on = !shared_column_strobe_n[0] && !(&bank_row_strobe_n);
  assign rd_on = col_on && dram_we_n;
  always_ff @(posedge clk) begin
    if (col_on && !dram_we_n && !dram_dq_oe_n) word_reg[bank] <= {dram_ecc_out, dram_dq_out};
  end
  always_ff @(posedge clk) begin
    if (rd_on) last_reg <= word_reg[bank] ^ {8'h00, flip_mask};
  end
  // A released bus must not look like it still holds the word, so it shows the inverse.
  assign {dram_ecc_in, dram_dq_in} = rd_on ? word_reg[bank] ^ {8'h00, flip_mask} : ~last_reg;
endmodule
